// File: rtl/tmio_core.v
// Function
// - or select register chooses or sources
// - and select register chooses and sources
// - backplane lines at bits 20 to 27
// - star bit 28, diff star bit 29
// - enabled source active while level high
// - three io lines, each input or output
// - reset and reset command leave lines undriven
// - one primary mode per line only
// - read-only supported-mode mask per line
// - code 1 unclocked input, level readable
// - code 4 sampled into sample word
// - code 8 replays embedded digital bit
// - trigger indicator high trigger to end
// - running indicator high while running
// - armed indicator high while armed, running and no trigger seen
// - code 1000h outputs pll reference clock
// - code 2000h outputs replay marker pulse
// - code 4000h outputs system clock
// - code 8000h line n outputs pulse gen n
// - new modes apply on start or setup
`include "tmio_defines.vh"

module tmio_core #(
    parameter [31:0] LINE0_SUPPORTED = 32'h0000f32f,
    parameter [31:0] LINE1_SUPPORTED = 32'h0000f32f,
    parameter [31:0] LINE2_SUPPORTED = 32'h0000f32f
) (
    input  wire        clk,
    input  wire        sys_rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [7:0]  backplane_trig_in,
    input  wire        star_trig_in,
    input  wire        diff_star_in,
    input  wire [2:0]  io_line_in,
    output reg  [2:0]  io_line_out,
    output reg  [2:0]  io_line_oe_n,
    output reg  [2:0]  io_line_sampled,
    input  wire [2:0]  unclocked_io_data,
    input  wire [2:0]  replay_digital_bit,
    input  wire        trig_seen,
    input  wire        acq_running,
    input  wire        acq_armed,
    input  wire        pll_ref_clk,
    input  wire        system_clk_in,
    input  wire        replay_marker,
    input  wire [2:0]  pulse_gen_in,
    output reg         trigger_out,
    output reg         digital_in_merge,
    output reg  [2:0]  active_async_out
);

    reg  [31:0] or_sel_q;
    reg  [31:0] and_sel_q;
    reg  [31:0] func_pend_q [0:2];
    reg  [31:0] func_act_q  [0:2];
    reg         trig_ind_q;
    reg  [31:0] rd_d;
    reg         err_d;
    reg  [2:0]  out_d;
    reg  [2:0]  oe_n_d;
    reg  [31:0] mode_v;
    reg         merge_d;
    reg  [2:0]  aout_d;
    wire [15:0] idx = paddr[17:2];
    wire        acc = psel & penable;
    wire        wr  = acc & pwrite;
    wire        apply = wr && idx == `TMIO_IDX_COMMAND &&
                        (pwdata[`TMIO_CMD_START_BIT] | pwdata[`TMIO_CMD_SETUP_BIT]);
    wire        rst_cmd = wr && idx == `TMIO_IDX_COMMAND && pwdata[`TMIO_CMD_RESET_BIT];
    wire        setup   = psel & ~penable;
    wire        wr_ok   = wr & pready & ~pslverr;

    // decoded register hits
    wire        hit_or   = idx == `TMIO_IDX_OR_SEL;
    wire        hit_and  = idx == `TMIO_IDX_AND_SEL;
    wire [2:0]  hit_func = {idx == `TMIO_IDX_LINE2_FUNC, idx == `TMIO_IDX_LINE1_FUNC,
                            idx == `TMIO_IDX_LINE0_FUNC};
    wire [2:0]  mode_ok;

    wire [31:0] src_vec;
    wire [31:0] or_hit;
    wire        and_ok;
    integer     i;

    // backplane lines at bits 20 to 27
    // star bit 28, diff star bit 29
    assign src_vec = {2'b00, diff_star_in, star_trig_in, backplane_trig_in, 20'h00000};
    assign or_hit  = src_vec & or_sel_q & `TMIO_SRC_MASK;
    // every and source high, empty mask passes
    assign and_ok  = ((and_sel_q & `TMIO_SRC_MASK) & ~src_vec) == 32'h00000000;

    function [31:0] supp_of;
        input [1:0] n;
        begin
            case (n)
                2'd0:    supp_of = LINE0_SUPPORTED;
                2'd1:    supp_of = LINE1_SUPPORTED;
                default: supp_of = LINE2_SUPPORTED;
            endcase
        end
    endfunction

    function legal_mode;
        input [31:0] v;
        input [1:0]  n;
        reg   [31:0] p;
        begin
            p = v & `TMIO_PRIMARY_MASK;
            legal_mode = ((p & (p - 32'h00000001)) == 32'h00000000) &&
                         ((v & ~(`TMIO_PRIMARY_MASK | `TMIO_DIGOUT_SRC_MASK)) == 32'h0) &&
                         ((p & ~supp_of(n)) == 32'h00000000) &&
                         ((v & `TMIO_DIGOUT_SRC_MASK) == 32'h0 || p == `TMIO_MODE_DIG_OUT);
        end
    endfunction

    // legality of the written word per line
    assign mode_ok[0] = legal_mode(pwdata, 2'd0);
    assign mode_ok[1] = legal_mode(pwdata, 2'd1);
    assign mode_ok[2] = legal_mode(pwdata, 2'd2);

    always @*
    begin
        rd_d  = 32'h00000000;
        case (idx)
            `TMIO_IDX_OR_SEL:     rd_d = or_sel_q;
            `TMIO_IDX_AND_SEL:    rd_d = and_sel_q;
            `TMIO_IDX_LINE0_FUNC: rd_d = func_pend_q[0];
            `TMIO_IDX_LINE1_FUNC: rd_d = func_pend_q[1];
            `TMIO_IDX_LINE2_FUNC: rd_d = func_pend_q[2];
            `TMIO_IDX_LINE0_SUPP: rd_d = LINE0_SUPPORTED;
            `TMIO_IDX_LINE1_SUPP: rd_d = LINE1_SUPPORTED;
            `TMIO_IDX_LINE2_SUPP: rd_d = LINE2_SUPPORTED;
            `TMIO_IDX_COMMAND:    rd_d = 32'h00000000;
            `TMIO_IDX_STATUS:     rd_d = {28'h0000000, trigger_out, io_line_in};
            default:              rd_d = 32'h00000000;
        endcase
    end

    // refused accesses answer with an error
    always @*
    begin
        err_d = 1'b0;
        case (idx)
            `TMIO_IDX_LINE0_SUPP, `TMIO_IDX_LINE1_SUPP, `TMIO_IDX_LINE2_SUPP,
            `TMIO_IDX_STATUS:     err_d = pwrite;
            `TMIO_IDX_OR_SEL, `TMIO_IDX_AND_SEL, `TMIO_IDX_COMMAND:
                                  err_d = 1'b0;
            `TMIO_IDX_LINE0_FUNC, `TMIO_IDX_LINE1_FUNC, `TMIO_IDX_LINE2_FUNC:
                                  err_d = pwrite && (hit_func & ~mode_ok) != 3'b000;
            default:              err_d = 1'b1;
        endcase
        if (paddr[1:0] != 2'b00 || paddr[31:18] != 14'h0000)
            err_d = 1'b1;
    end

    // three lines, each input or output
    // per line drive selection from the applied mode
    always @*
    begin
        out_d   = 3'b000;
        oe_n_d  = 3'b111;
        merge_d = 1'b0;
        aout_d  = 3'b000;
        mode_v  = 32'h00000000;
        for (i = 0; i < 3; i = i + 1)
        begin
            mode_v = func_act_q[i] & `TMIO_PRIMARY_MASK;
            case (mode_v)
                `TMIO_MODE_OFF:       oe_n_d[i] = 1'b1;
                `TMIO_MODE_ASYNC_IN:  oe_n_d[i] = 1'b1;
                `TMIO_MODE_ASYNC_OUT:
                begin
                    out_d[i]  = unclocked_io_data[i];
                    oe_n_d[i] = 1'b0;
                    aout_d[i] = 1'b1;
                end
                `TMIO_MODE_DIG_IN:    merge_d = 1'b1;
                `TMIO_MODE_DIG_OUT:
                begin
                    out_d[i]  = replay_digital_bit[i];
                    oe_n_d[i] = 1'b0;
                end
                `TMIO_MODE_TRIG:
                begin
                    out_d[i]  = trig_ind_q;
                    oe_n_d[i] = 1'b0;
                end
                `TMIO_MODE_RUN:
                begin
                    out_d[i]  = acq_running;
                    oe_n_d[i] = 1'b0;
                end
                `TMIO_MODE_ARM:
                begin
                    out_d[i]  = acq_armed & acq_running & ~trig_seen;
                    oe_n_d[i] = 1'b0;
                end
                `TMIO_MODE_REFCLK:
                begin
                    out_d[i]  = pll_ref_clk;
                    oe_n_d[i] = 1'b0;
                end
                `TMIO_MODE_MARKER:
                begin
                    out_d[i]  = replay_marker;
                    oe_n_d[i] = 1'b0;
                end
                `TMIO_MODE_SYSCLK:
                begin
                    out_d[i]  = system_clk_in;
                    oe_n_d[i] = 1'b0;
                end
                // pulse generator n on line n
                `TMIO_MODE_PULSE:
                begin
                    out_d[i]  = pulse_gen_in[i];
                    oe_n_d[i] = 1'b0;
                end
                default:              oe_n_d[i] = 1'b1;
            endcase
        end
    end

    // apb answer one cycle after setup
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= setup;
            prdata  <= (setup & ~pwrite) ? rd_d : 32'h00000000;
            pslverr <= setup & err_d;
        end
    end

    always @(posedge clk)
    begin
        if (sys_rst)
            or_sel_q <= `TMIO_RESET_VAL;
        else if (wr_ok && hit_or)
            or_sel_q <= pwdata & `TMIO_SRC_MASK;
    end

    always @(posedge clk)
    begin
        if (sys_rst)
            and_sel_q <= `TMIO_RESET_VAL;
        else if (wr_ok && hit_and)
            and_sel_q <= pwdata & `TMIO_SRC_MASK;
    end

    always @(posedge clk)
    begin
        if (sys_rst || (wr_ok && rst_cmd))
        begin
            func_pend_q[0] <= `TMIO_MODE_OFF;
            func_pend_q[1] <= `TMIO_MODE_OFF;
            func_pend_q[2] <= `TMIO_MODE_OFF;
        end
        else if (wr_ok)
        begin
            if (hit_func[0])
                func_pend_q[0] <= pwdata;
            if (hit_func[1])
                func_pend_q[1] <= pwdata;
            if (hit_func[2])
                func_pend_q[2] <= pwdata;
        end
    end

    always @(posedge clk)
    begin
        if (sys_rst || (wr_ok && rst_cmd))
        begin
            func_act_q[0] <= `TMIO_MODE_OFF;
            func_act_q[1] <= `TMIO_MODE_OFF;
            func_act_q[2] <= `TMIO_MODE_OFF;
        end
        else if (wr_ok && apply)
        begin
            func_act_q[0] <= func_pend_q[0];
            func_act_q[1] <= func_pend_q[1];
            func_act_q[2] <= func_pend_q[2];
        end
    end

    // high on trigger, low at end
    always @(posedge clk)
    begin
        if (sys_rst)
            trig_ind_q <= 1'b0;
        else if (trig_seen && acq_running)
            trig_ind_q <= 1'b1;
        else if (!acq_running)
            trig_ind_q <= 1'b0;
    end

    // or hit and every and source
    always @(posedge clk)
    begin
        if (sys_rst)
            trigger_out <= 1'b0;
        else
            trigger_out <= (or_hit != 32'h00000000) & and_ok;
    end

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            io_line_out  <= 3'b000;
            io_line_oe_n <= 3'b111;
        end
        else
        begin
            io_line_out  <= out_d;
            io_line_oe_n <= oe_n_d;
        end
    end

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            io_line_sampled  <= 3'b000;
            digital_in_merge <= 1'b0;
            active_async_out <= 3'b000;
        end
        else
        begin
            io_line_sampled  <= io_line_in;
            digital_in_merge <= merge_d;
            active_async_out <= aout_d;
        end
    end

endmodule // tmio_core

// File: shared/tmio_defines.vh
`ifndef TMIO_DEFINES_VH
`define TMIO_DEFINES_VH

// register indices (byte address is four times the index)
`define TMIO_IDX_OR_SEL      16'h9dda
`define TMIO_IDX_AND_SEL     16'h9dee
`define TMIO_IDX_LINE0_FUNC  16'hb860
`define TMIO_IDX_LINE1_FUNC  16'hb861
`define TMIO_IDX_LINE2_FUNC  16'hb862
`define TMIO_IDX_LINE0_SUPP  16'hb86a
`define TMIO_IDX_LINE1_SUPP  16'hb86b
`define TMIO_IDX_LINE2_SUPP  16'hb86c
`define TMIO_IDX_COMMAND     16'hb870
`define TMIO_IDX_STATUS      16'hb871

// mask field: backplane lines 0..7 at bits 20..27, star 28, diff star in 29
`define TMIO_BP_LSB          5'd20
`define TMIO_BP_MSB          5'd27
`define TMIO_STAR_BIT        5'd28
`define TMIO_DSTAR_BIT       5'd29
`define TMIO_SRC_MASK        32'h3ff00000

// line function codes
`define TMIO_MODE_OFF        32'h00000000
`define TMIO_MODE_ASYNC_IN   32'h00000001
`define TMIO_MODE_ASYNC_OUT  32'h00000002
`define TMIO_MODE_DIG_IN     32'h00000004
`define TMIO_MODE_DIG_OUT    32'h00000008
`define TMIO_MODE_TRIG       32'h00000020
`define TMIO_MODE_RUN        32'h00000100
`define TMIO_MODE_ARM        32'h00000200
`define TMIO_MODE_REFCLK     32'h00001000
`define TMIO_MODE_MARKER     32'h00002000
`define TMIO_MODE_SYSCLK     32'h00004000
`define TMIO_MODE_PULSE      32'h00008000
`define TMIO_PRIMARY_MASK    32'h0000f3ff
`define TMIO_DIGOUT_SRC_MASK 32'h0ff00000

// command register bits
`define TMIO_CMD_START_BIT   5'd0
`define TMIO_CMD_SETUP_BIT   5'd1
`define TMIO_CMD_RESET_BIT   5'd2

`define TMIO_RESET_VAL       32'h00000000

`endif

// File: tb/tmio_props.sv
`include "tmio_defines.vh"
module tmio_props (
    input logic        clk,
    input logic        sys_rst,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [31:0] paddr,
    input logic [31:0] pwdata,
    input logic        pready,
    input logic        pslverr,
    input logic [7:0]  backplane_trig_in,
    input logic        star_trig_in,
    input logic        diff_star_in,
    input logic [2:0]  io_line_oe_n,
    input logic        trigger_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    logic        setup;
    logic        wr_ok;
    logic [15:0] idx;
    assign setup = psel && !penable;
    assign wr_ok = psel && penable && pready && pwrite && !pslverr;
    assign idx = paddr[17:2];
    a_ready_next: assert property (setup |=> pready)
        else $error("no answer in access cycle");
    a_ready_once: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_quiet_sources: assert property (!(|backplane_trig_in) && !star_trig_in && !diff_star_in |=> !trigger_out)
        else $error("trigger with no active source");
    a_reset_release: assert property ($fell(sys_rst) |-> io_line_oe_n == 3'b111 && !trigger_out)
        else $error("lines driven after reset");
    a_reset_cmd: assert property (wr_ok && idx == `TMIO_IDX_COMMAND && pwdata[2] |-> ##[1:2] io_line_oe_n == 3'b111)
        else $error("reset command left a line driven");
    a_mode_deferred: assert property (wr_ok && idx inside {`TMIO_IDX_LINE0_FUNC, `TMIO_IDX_LINE1_FUNC, `TMIO_IDX_LINE2_FUNC} |=> ##1 $stable(io_line_oe_n))
        else $error("mode applied before command");
    a_ro_refused: assert property (setup && pwrite && idx inside {`TMIO_IDX_LINE0_SUPP, `TMIO_IDX_LINE1_SUPP, `TMIO_IDX_LINE2_SUPP} |=> pslverr)
        else $error("write to supported mask accepted");
    a_single_mode: assert property (setup && pwrite && idx == `TMIO_IDX_LINE0_FUNC && $countones(pwdata & `TMIO_PRIMARY_MASK) > 1 |=> pslverr)
        else $error("combined modes accepted");
    c_trigger: cover property (trigger_out);
    c_refused: cover property (pready && pslverr);
    c_apply: cover property (wr_ok && idx == `TMIO_IDX_COMMAND);
endmodule // tmio_props

bind tmio_core tmio_props u_props (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .backplane_trig_in(backplane_trig_in), .star_trig_in(star_trig_in),
    .diff_star_in(diff_star_in), .io_line_oe_n(io_line_oe_n), .trigger_out(trigger_out));

// File: tb/tmio_far_end.sv
module tmio_far_end (
    input  logic       clk,
    input  logic [9:0] src_want,
    input  logic [2:0] ext_val,
    input  logic [2:0] ext_en,
    input  logic [2:0] line_out,
    input  logic [2:0] line_oe_n,
    output logic [7:0] bp_lines,
    output logic       star_line,
    output logic       dstar_line,
    output logic [2:0] line_level
);
    timeunit 1ns;
    timeprecision 1ns;
    // sources launched a clock after request, active high
    always @(posedge clk)
    begin
        {dstar_line, star_line, bp_lines} <= src_want;
    end
    // undriven lines float high through the pull-ups
    always_comb
    begin
        for (int i = 0; i < 3; i++)
            line_level[i] = !line_oe_n[i] ? line_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
    end
endmodule // tmio_far_end

// File: tb/test_trigger_mask_and_mpio_lines.sv
`include "tmio_defines.vh"
module test_trigger_mask_and_mpio_lines;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] SUPP = 32'h0000f32f;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, trig, merge, star, dstar, inp;
    logic [7:0]  bp;
    logic [2:0]  lvl, lout, oe_n, smp, aout;
    logic [14:0] card = 15'h0;
    logic        trig_m = 1'b0;
    logic [9:0]  src = 10'h0;
    logic [2:0]  ext_val = 3'h0;
    logic [2:0]  ext_en = 3'h0;
    logic [32:0] exp_q[$];
    logic [32:0] e;
    logic [31:0] m[3] = '{default: 32'h0};
    logic [31:0] code[11] = '{32'h1, 32'h2, 32'h4, 32'h01100008, 32'h20, 32'h100, 32'h200,
                              32'h1000, 32'h2000, 32'h4000, 32'h8000};
    logic [31:0] bad[4] = '{32'h3, 32'h10, 32'h01000000, 32'h00008020};
    logic [10:0] and_case[4] = '{11'h407, 11'h003, 11'h005, 11'h006};
    logic [15:0] rd_idx[8] = '{`TMIO_IDX_OR_SEL, `TMIO_IDX_AND_SEL, `TMIO_IDX_LINE0_FUNC,
        `TMIO_IDX_LINE1_FUNC, `TMIO_IDX_LINE2_FUNC, `TMIO_IDX_LINE0_SUPP,
        `TMIO_IDX_LINE1_SUPP, `TMIO_IDX_LINE2_SUPP};
    logic [31:0] v;
    int          seed = 98;
    int          n_mismatch = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          n;

    tmio_core #(.LINE0_SUPPORTED(SUPP), .LINE1_SUPPORTED(SUPP), .LINE2_SUPPORTED(SUPP)) i_dut (
        .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .backplane_trig_in(bp), .star_trig_in(star), .diff_star_in(dstar),
        .io_line_in(lvl), .io_line_out(lout), .io_line_oe_n(oe_n), .io_line_sampled(smp),
        .unclocked_io_data(card[2:0]), .replay_digital_bit(card[5:3]), .trig_seen(card[6]),
        .acq_running(card[7]), .acq_armed(card[8]), .pll_ref_clk(card[9]),
        .system_clk_in(card[10]), .replay_marker(card[11]), .pulse_gen_in(card[14:12]),
        .trigger_out(trig), .digital_in_merge(merge), .active_async_out(aout));
    tmio_far_end i_far (.clk(clk), .src_want(src), .ext_val(ext_val), .ext_en(ext_en),
        .line_out(lout), .line_oe_n(oe_n), .bp_lines(bp), .star_line(star),
        .dstar_line(dstar), .line_level(lvl));

    always #50 clk = ~clk;

    task automatic check(input logic [32:0] seen, input logic [32:0] want);
        tests_run++;
        if (seen !== want)
        begin
            n_mismatch++;
            $display("MISMATCH at %0t seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic finish_test();
        if (n_mismatch == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d,
                       input logic [32:0] x);
        exp_q.push_back(x);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {14'h0, idx, 2'b00};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
    endtask

    task automatic idle(input int k);
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (k) @(posedge clk);
    endtask

    function automatic logic drv(input logic [31:0] c, input int k);
        case (c[15:0])
            16'h0002: return card[k];
            16'h0008: return card[3 + k];
            16'h0020: return trig_m;
            16'h0100: return card[7];
            16'h0200: return card[8] & card[7] & ~card[6];
            16'h1000: return card[9];
            16'h2000: return card[11];
            16'h4000: return card[10];
            default: return card[12 + k];
        endcase
    endfunction

    // completed transfers against the oldest note, plus a hang limit
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        // indicator model, set on trigger, cleared when stopped
        trig_m <= (card[6] & card[7]) | (trig_m & card[7]);
        if (psel && penable && pready && exp_q.size() > 0)
        begin
            e = exp_q.pop_front();
            check({pslverr, pwrite ? 32'h0 : prdata}, e);
        end
        if (cycles == 3000)
        begin
            n_mismatch++;
            finish_test();
        end
    end

    initial
    begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        idle(2);
        check({oe_n, smp}, 33'h3f);
        foreach (rd_idx[i]) apb(1'b0, rd_idx[i], 32'h0, {1'b0, i < 5 ? 32'h0 : SUPP});
        for (int k = 0; k < 2; k++)
        begin
            v = $random(seed);
            apb(1'b1, rd_idx[k], v, 33'h0);
            apb(1'b0, rd_idx[k], 32'h0, {1'b0, v & `TMIO_SRC_MASK});
        end
        apb(1'b1, `TMIO_IDX_AND_SEL, 32'h0, 33'h0);
        for (int i = 0; i < 10; i++)
        begin
            // line already set to input on the far side
            apb(1'b1, `TMIO_IDX_OR_SEL, 32'h1 << (20 + i), 33'h0);
            src <= 10'h1 << i;
            idle(3);
            check(trig, 1'b1);
            src <= ~(10'h1 << i);
            idle(3);
            check(trig, 1'b0);
        end
        apb(1'b1, `TMIO_IDX_OR_SEL, 32'h00100000, 33'h0);
        apb(1'b1, `TMIO_IDX_AND_SEL, 32'h00600000, 33'h0);
        foreach (and_case[i])
        begin
            src <= and_case[i][9:0];
            idle(3);
            check(trig, and_case[i][10]);
        end
        for (int i = 0; i < 11; i++)
        begin
            n = i % 3;
            inp = code[i] == 32'h1 || code[i] == 32'h4;
            card <= 15'($random(seed));
            ext_en[n] <= 1'b0;
            apb(1'b1, 16'(`TMIO_IDX_LINE0_FUNC + n), code[i], 33'h0);
            apb(1'b0, 16'(`TMIO_IDX_LINE0_FUNC + n), 32'h0, {1'b0, code[i]});
            apb(1'b1, `TMIO_IDX_COMMAND, i % 2 ? 32'h1 : 32'h2, 33'h0);
            m[n] = code[i];
            idle(3);
            ext_en[n] <= inp;
            ext_val <= 3'($random(seed));
            idle(2);
            check(oe_n[n], inp);
            check(inp ? smp[n] : lout[n], inp ? ext_val[n] : drv(code[i], n));
            check({merge, aout[n]}, {m[0] == 32'h4 || m[1] == 32'h4 || m[2] == 32'h4, code[i] == 32'h2});
        end
        foreach (bad[i]) apb(1'b1, `TMIO_IDX_LINE0_FUNC, bad[i], {1'b1, 32'h0});
        apb(1'b1, `TMIO_IDX_LINE2_SUPP, 32'h0, {1'b1, 32'h0});
        apb(1'b1, 16'h0001, 32'h0, {1'b1, 32'h0});
        apb(1'b0, `TMIO_IDX_LINE0_FUNC, 32'h0, {1'b0, m[0]});
        apb(1'b1, `TMIO_IDX_COMMAND, 32'h4, 33'h0);
        ext_en <= 3'h0;
        idle(3);
        check({oe_n, merge, aout}, 33'h70);
        apb(1'b0, `TMIO_IDX_LINE1_FUNC, 32'h0, 33'h0);
        apb(1'b0, `TMIO_IDX_STATUS, 32'h0, {1'b0, 32'h7});
        idle(2);
        finish_test();
    end
endmodule // test_trigger_mask_and_mpio_lines
